// ### rtl/hpi_map.svh
`ifndef HPI_MAP_SVH
`define HPI_MAP_SVH

// pin indices within the host port pin vectors
`define HPI_PIN_READY 0
`define HPI_PIN_IRQ 1
`define HPI_PIN_DMA_REQUEST 2
`define HPI_PIN_CHIP_SELECT 3
`define HPI_PIN_REGISTER_SELECT 4
`define HPI_PIN_WRITE_STROBE 5
`define HPI_PIN_READ_STROBE 6
`define HPI_PIN_DATA_BASE 7

// widths and counts
`define HPI_DATA_WIDTH 16
`define HPI_CTRL_PINS 7
`define HPI_SYNC_STAGES 2

// reset values
`define HPI_SYNC_RESET 1'h0
`define HPI_STROBE_IDLE 1'h1

`endif

// ### rtl/hpi_pkg.sv
`default_nettype none
package hpi_pkg;
	// one-hot port mode
	typedef enum logic [3:0] {
		HPI_ST_RESET_BOOT = 4'h1,
		HPI_ST_RESET_GEN = 4'h2,
		HPI_ST_RUN_BOOT = 4'h4,
		HPI_ST_RUN_GEN = 4'h8
	} hpi_mode_t;
endpackage
`default_nettype wire

// ### rtl/hpi_sync_if.sv
`default_nettype none
interface hpi_sync_if;
	logic raw;
	logic sync;
	modport core (output raw, input sync);
	modport sync_end (input raw, output sync);
endinterface
`default_nettype wire

// ### rtl/hpi_sync.sv
`include "hpi_map.svh"
`default_nettype none
module hpi_sync (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_reset,
	// level to synchronise
	hpi_sync_if.sync_end sif
);
	logic [`HPI_SYNC_STAGES-1:0] stage_reg;

	// ----------------------------------------
	// two-stage level synchroniser
	// ----------------------------------------
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			stage_reg <= {`HPI_SYNC_STAGES{`HPI_SYNC_RESET}};
		end else begin
			stage_reg <= {stage_reg[`HPI_SYNC_STAGES-2:0], sif.raw};
		end
	end

	assign sif.sync = stage_reg[`HPI_SYNC_STAGES-1];
endmodule
`default_nettype wire

// ### rtl/hpi_pin_isolation.sv
// Contract
// - enable low with isolation role: all host pins float, inputs disabled.
// - reset with boot high: ready driven low, all else off.
// - after boot release with enable low: every host buffer stays off.
// - boot run with enable high: sequence outputs, inputs on, data direction from strobes.
// - reset with boot low: all pins general inputs, enable level ignored.
// - after non-boot release: all pins general inputs until functions are reassigned.
// - pin function selector can give the shared pin its isolation enable role.
// - pin function selector gives each pin its host role individually.
// - both roles selected: buffers gated by isolation enable level.
// - host role without isolation role: buffers held off; software must avoid.
`include "hpi_map.svh"
`default_nettype none
module hpi_pin_isolation #(
	parameter int DATA_W = `HPI_DATA_WIDTH,
	parameter int NUM_PINS = `HPI_CTRL_PINS + `HPI_DATA_WIDTH
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_reset,
	// device straps and isolation pin
	input wire logic i_external_reset_pin_n,
	input wire logic i_boot_select_input,
	input wire logic i_host_pin_isolation_enable,
	// pin function selector
	input wire logic i_pin_function_selector_isolation,
	input wire logic [NUM_PINS-1:0] i_pin_function_selector_host,
	// protocol sequence side
	input wire logic i_seq_host_ready_out,
	input wire logic i_seq_host_irq_out,
	input wire logic i_seq_host_dma_request_out,
	input wire logic [DATA_W-1:0] i_seq_host_data_bus,
	// pin levels
	input wire logic [NUM_PINS-1:0] i_pin_level,
	// pin drive
	output logic [NUM_PINS-1:0] o_pin_out,
	output logic [NUM_PINS-1:0] o_pin_oe,
	// gated inputs toward the host protocol
	output logic [NUM_PINS-1:0] o_host_in,
	output logic [NUM_PINS-1:0] o_host_in_enable,
	// general input port view
	output logic [NUM_PINS-1:0] o_general_in,
	output logic [NUM_PINS-1:0] o_general_role,
	// status
	output hpi_pkg::hpi_mode_t o_mode,
	output logic o_isolation_enable_sync,
	output logic o_host_port_active
);
	import hpi_pkg::*;

	hpi_mode_t mode_reg;
	hpi_mode_t mode_next;
	logic in_reset;
	logic boot_reset;
	logic iso_role;
	logic iso_high;
	logic data_drive;
	logic [NUM_PINS-1:0] host_role;
	logic [NUM_PINS-1:0] live;
	logic [NUM_PINS-1:0] seq_value;
	logic [NUM_PINS-1:0] out_next;
	logic [NUM_PINS-1:0] oe_next;
	logic [NUM_PINS-1:0] in_en_next;
	logic [NUM_PINS-1:0] host_in_next;
	logic [NUM_PINS-1:0] gen_in_next;
	logic [NUM_PINS-1:0] gen_role_next;
	logic [NUM_PINS-1:0] out_reg;
	logic [NUM_PINS-1:0] oe_reg;
	logic [NUM_PINS-1:0] in_en_reg;
	logic [NUM_PINS-1:0] host_in_reg;
	logic [NUM_PINS-1:0] gen_in_reg;
	logic [NUM_PINS-1:0] gen_role_reg;
	logic active_reg;

	hpi_sync_if sif ();

	// ----------------------------------------
	// enable synchroniser
	// ----------------------------------------
	assign sif.raw = i_host_pin_isolation_enable;

	hpi_sync u_sync (
		.i_clk(i_clk),
		.i_reset(i_reset),
		.sif(sif)
	);

	// ----------------------------------------
	// port mode, boot level caught in reset
	// ----------------------------------------
	always_comb begin
		mode_next = mode_reg;
		case (mode_reg)
			HPI_ST_RESET_BOOT, HPI_ST_RESET_GEN: begin
				if (!i_external_reset_pin_n) begin
					mode_next = i_boot_select_input ? HPI_ST_RESET_BOOT : HPI_ST_RESET_GEN;
				end else begin
					mode_next = i_boot_select_input ? HPI_ST_RUN_BOOT : HPI_ST_RUN_GEN;
				end
			end
			HPI_ST_RUN_BOOT, HPI_ST_RUN_GEN: begin
				if (!i_external_reset_pin_n) begin
					mode_next = i_boot_select_input ? HPI_ST_RESET_BOOT : HPI_ST_RESET_GEN;
				end
			end
			default: begin
				mode_next = HPI_ST_RESET_GEN;
			end
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			mode_reg <= HPI_ST_RESET_GEN;
		end else begin
			mode_reg <= mode_next;
		end
	end

	// ----------------------------------------
	// role selection
	// ----------------------------------------
	assign in_reset = (mode_next == HPI_ST_RESET_BOOT) || (mode_next == HPI_ST_RESET_GEN);
	assign boot_reset = (mode_next == HPI_ST_RESET_BOOT);
	// boot run forces both roles; non-boot run follows the selector
	assign iso_role = (mode_next == HPI_ST_RUN_BOOT) ||
		((mode_next == HPI_ST_RUN_GEN) && i_pin_function_selector_isolation);
	assign iso_high = iso_role && i_host_pin_isolation_enable;
	// device drives data only on a selected read
	assign data_drive = !i_pin_level[`HPI_PIN_CHIP_SELECT] && !i_pin_level[`HPI_PIN_READ_STROBE] &&
		i_pin_level[`HPI_PIN_WRITE_STROBE];

	assign seq_value[`HPI_PIN_READY] = i_seq_host_ready_out;
	assign seq_value[`HPI_PIN_IRQ] = i_seq_host_irq_out;
	assign seq_value[`HPI_PIN_DMA_REQUEST] = i_seq_host_dma_request_out;
	assign seq_value[`HPI_PIN_DATA_BASE-1:`HPI_PIN_CHIP_SELECT] = '0;
	assign seq_value[NUM_PINS-1:`HPI_PIN_DATA_BASE] = i_seq_host_data_bus;

	// ----------------------------------------
	// per-pin buffer control
	// ----------------------------------------
	genvar p;
	generate
		for (p = 0; p < NUM_PINS; p++) begin : g_pin
			assign host_role[p] = boot_reset || (mode_next == HPI_ST_RUN_BOOT) ||
				((mode_next == HPI_ST_RUN_GEN) && i_pin_function_selector_host[p]);
			// both roles and enable high; isolation role absent keeps all off
			assign live[p] = !in_reset && host_role[p] && iso_high;

			always_comb begin
				out_next[p] = 1'h0;
				oe_next[p] = 1'h0;
				in_en_next[p] = 1'h0;
				host_in_next[p] = (p < `HPI_PIN_DATA_BASE) ? `HPI_STROBE_IDLE : 1'h0;
				gen_role_next[p] = !host_role[p];
				gen_in_next[p] = host_role[p] ? 1'h0 : i_pin_level[p];
				if (boot_reset) begin
					// ready low, everything else off
					if (p == `HPI_PIN_READY) begin
						oe_next[p] = 1'h1;
					end
				end else if (live[p]) begin
					if (p < `HPI_PIN_CHIP_SELECT) begin
						oe_next[p] = 1'h1;
						out_next[p] = seq_value[p];
					end else if (p >= `HPI_PIN_DATA_BASE) begin
						oe_next[p] = data_drive;
						out_next[p] = seq_value[p];
						in_en_next[p] = !data_drive;
						host_in_next[p] = data_drive ? 1'h0 : i_pin_level[p];
					end else begin
						in_en_next[p] = 1'h1;
						host_in_next[p] = i_pin_level[p];
					end
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// registered pin outputs
	// ----------------------------------------
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			out_reg <= '0;
			oe_reg <= '0;
		end else begin
			out_reg <= out_next;
			oe_reg <= oe_next;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			in_en_reg <= '0;
			host_in_reg <= {{DATA_W{1'h0}}, {`HPI_CTRL_PINS{`HPI_STROBE_IDLE}}};
		end else begin
			in_en_reg <= in_en_next;
			host_in_reg <= host_in_next;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			gen_in_reg <= '0;
			gen_role_reg <= '1;
		end else begin
			gen_in_reg <= gen_in_next;
			gen_role_reg <= gen_role_next;
		end
	end

	// ----------------------------------------
	// sequenced status uses the synchronised enable
	// ----------------------------------------
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			active_reg <= 1'h0;
		end else begin
			active_reg <= !in_reset && iso_role && sif.sync;
		end
	end

	assign o_pin_out = out_reg;
	assign o_pin_oe = oe_reg;
	assign o_host_in = host_in_reg;
	assign o_host_in_enable = in_en_reg;
	assign o_general_in = gen_in_reg;
	assign o_general_role = gen_role_reg;
	assign o_mode = mode_reg;
	assign o_isolation_enable_sync = sif.sync;
	assign o_host_port_active = active_reg;
endmodule
`default_nettype wire

// ### testbench/hpi_host_model.sv
`default_nettype none
module hpi_host_model (
	// clock and host power
	input wire logic i_clk,
	input wire logic i_power,
	// host strobes {read, write, register, select} and write data
	input wire logic [3:0] i_ctl,
	input wire logic [15:0] i_wdata,
	// device pin drive
	input wire logic [22:0] i_oe,
	input wire logic [22:0] i_out,
	// enable pin and resolved pin levels
	output logic o_enable,
	output logic [22:0] o_level
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [22:0] drv;
	logic [22:0] last = '0;
	// strobes driven while powered, data only while writing
	assign drv = i_power ? {{16{!i_ctl[2]}}, 7'h78} : '0;
	assign o_enable = i_power;
	// floating lines show the inverse of their last level
	assign o_level = (i_oe & i_out) | (~i_oe & drv & {i_wdata, i_ctl, 3'h0}) | (~i_oe & ~drv & ~last);
	always @(posedge i_clk) last <= o_level;
endmodule
`default_nettype wire

// ### testbench/hpi_pin_isolation_assertions.sv
`default_nettype none
module hpi_pin_isolation_assertions
	import hpi_pkg::*;
#(
	parameter int DATA_W = 16,
	parameter int NUM_PINS = 23
) (
	// clock, reset, straps, selector, sequence
	input wire logic i_clk, i_reset, i_external_reset_pin_n, i_boot_select_input,
	input wire logic i_host_pin_isolation_enable, i_pin_function_selector_isolation, i_seq_host_ready_out,
	input wire logic [NUM_PINS-1:0] i_pin_function_selector_host, i_pin_level,
	// pin results
	input wire logic [NUM_PINS-1:0] o_pin_out, o_pin_oe, o_host_in_enable, o_general_role, o_host_in, o_general_in,
	input wire hpi_mode_t o_mode,
	input wire logic o_isolation_enable_sync, o_host_port_active
);
	wire logic rn = i_external_reset_pin_n;
	wire logic en = i_host_pin_isolation_enable;
	logic pr;
	logic pr2;
	// reset history for look-back
	always_ff @(posedge i_clk) begin
		pr <= i_reset;
		pr2 <= pr;
	end
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_reset);
	// ---
	// assertions
	// ---
	boot_reset_a: assert property (!pr && $past(!rn && i_boot_select_input) |-> o_pin_oe == 23'h1 &&
		!o_pin_out[0] && o_host_in_enable == '0) else $error("boot reset buffers");
	gen_reset_a: assert property (!pr && $past(!rn && !i_boot_select_input) |->
		o_mode == HPI_ST_RESET_GEN && o_pin_oe == '0 && &o_general_role) else $error("gen reset buffers");
	pins_isolated_a: assert property (!pr && $past(rn && !en) |->
		o_pin_oe == '0 && o_host_in_enable == '0) else $error("not isolated");
	seq_drive_a: assert property (!pr && $past(rn && en) && o_mode == HPI_ST_RUN_BOOT |->
		o_pin_oe[2:0] == 3'h7 && o_pin_out[0] == $past(i_seq_host_ready_out) && o_host_in_enable[6:3] == 4'hF)
		else $error("sequence drive");
	data_dir_a: assert property (!pr && $past(rn && en) && o_mode == HPI_ST_RUN_BOOT |->
		o_pin_oe[22:7] == {16{$past(!i_pin_level[3] && !i_pin_level[6] && i_pin_level[5])}}) else $error("data dir");
	no_iso_a: assert property (!pr && o_mode == HPI_ST_RUN_GEN && $past(!i_pin_function_selector_isolation) |->
		o_pin_oe == '0 && o_host_in_enable == '0) else $error("buffers without isolation role");
	role_map_a: assert property (!pr && o_mode == HPI_ST_RUN_GEN |->
		o_general_role == ~$past(i_pin_function_selector_host)) else $error("role map");
	both_roles_a: assert property (!pr && o_mode == HPI_ST_RUN_GEN &&
		$past(en && i_pin_function_selector_isolation && i_pin_function_selector_host[0]) |-> o_pin_oe[0])
		else $error("both roles not driving");
	enable_sync_a: assert property (!pr && !pr2 |-> o_isolation_enable_sync == $past(en, 2)) else $error("sync");
	host_active_a: assert property (!pr |-> o_host_port_active == ($past(o_isolation_enable_sync) &&
		(o_mode == HPI_ST_RUN_BOOT || (o_mode == HPI_ST_RUN_GEN && $past(i_pin_function_selector_isolation)))))
		else $error("port active");
	general_in_a: assert property (!pr |-> o_general_in == ($past(i_pin_level) & o_general_role))
		else $error("general input value");
	host_in_a: assert property (!pr |-> o_host_in ==
		((o_host_in_enable & $past(i_pin_level)) | (~o_host_in_enable & 23'h0007F))) else $error("host input value");
	cover property (!pr && o_mode == HPI_ST_RESET_BOOT);
	cover property (o_mode == HPI_ST_RUN_BOOT && o_pin_oe[22:7] != '0);
	cover property (o_mode == HPI_ST_RUN_GEN && o_pin_oe != '0);
endmodule
bind hpi_pin_isolation hpi_pin_isolation_assertions #(.DATA_W(DATA_W), .NUM_PINS(NUM_PINS)) chk_u (.*);
`default_nettype wire

// ### testbench/tb.sv
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import hpi_pkg::*;
	logic clk = 1'h0, rst = 1'h1, rpin = 1'h0, boot = 1'h1, pwr = 1'h0;
	logic isel = 1'h0, rdy = 1'h0, irq = 1'h0, dma = 1'h0, en;
	logic [3:0] ctl = 4'hF;
	logic [15:0] sdat = '0, wdat = '0;
	logic [22:0] hsel = '0, lvl, oe, out, hen, grole;
	hpi_mode_t mode;
	integer seed = 6685, errors = 0, total_checks = 0, cyc = 0;
	hpi_pin_isolation dut (
		.i_clk(clk), .i_reset(rst), .i_external_reset_pin_n(rpin), .i_boot_select_input(boot),
		.i_host_pin_isolation_enable(en), .i_pin_function_selector_isolation(isel),
		.i_pin_function_selector_host(hsel), .i_seq_host_ready_out(rdy), .i_seq_host_irq_out(irq),
		.i_seq_host_dma_request_out(dma), .i_seq_host_data_bus(sdat), .i_pin_level(lvl), .o_pin_out(out),
		.o_pin_oe(oe), .o_host_in(), .o_host_in_enable(hen), .o_general_in(), .o_general_role(grole),
		.o_mode(mode), .o_isolation_enable_sync(), .o_host_port_active()
	);
	hpi_host_model host (.i_clk(clk), .i_power(pwr), .i_ctl(ctl), .i_wdata(wdat), .i_oe(oe), .i_out(out),
		.o_enable(en), .o_level(lvl));
	always #5 clk = ~clk;
	// expected drive (sel 0) or input enable (sel 1)
	function automatic logic [22:0] want(input logic [22:0] m, input logic e, input logic [3:0] c, input logic sel);
		logic d;
		d = !c[0] && !c[3] && c[2];
		if (sel) return m & {23{e}} & {{16{!d}}, 7'h78};
		return m & {23{e}} & {{16{d}}, 7'h07};
	endfunction
	task automatic chk(input logic [22:0] g, input logic [22:0] e, input string s);
		total_checks++;
		if (g !== e) begin
			errors++;
			$display("BAD %0t %s", $time, s);
		end
	endtask
	task automatic tick();
		@(posedge clk);
		#1;
	endtask
	task automatic finish_test();
		if (errors == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic run(input int n, input logic b);
		logic [22:0] m;
		for (int i = 0; i < n; i++) begin
			{pwr, ctl, rdy, irq, dma, isel} = $random(seed);
			{sdat, wdat} = $random(seed);
			hsel = $random(seed);
			if (i < 4) begin
				{pwr, ctl, isel, hsel} = {1'h1, 4'h6, 1'h1, 23'h7FFFFF};
			end
			tick();
			m = b ? '1 : hsel & {23{isel}};
			chk(mode, b ? HPI_ST_RUN_BOOT : HPI_ST_RUN_GEN, "mode");
			chk(oe, want(m, pwr, ctl, 1'h0), "drive");
			chk(hen, want(m, pwr, ctl, 1'h1), "input");
			chk(out & oe, {sdat, 4'h0, dma, irq, rdy} & want(m, pwr, ctl, 1'h0), "value");
			chk(grole, b ? 23'h0 : ~hsel, "role");
		end
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc > 2000) begin
			errors++;
			finish_test();
		end
	end
	initial begin
		repeat (2) @(posedge clk);
		#1;
		rst = 1'h0;
		for (int i = 0; i < 4; i++) begin
			pwr = i[0];
			tick();
			chk(oe, 23'h1, "boot reset drive");
			chk(hen | out, '0, "boot reset level");
		end
		boot = 1'h0;
		tick();
		chk(mode, HPI_ST_RESET_GEN, "gen reset mode");
		chk(oe | hen, '0, "gen reset buffers");
		rpin = 1'h1;
		tick();
		chk(grole, '1, "gen initial role");
		run(300, 1'h0);
		rpin = 1'h0;
		boot = 1'h1;
		tick();
		chk(oe, 23'h1, "mid reset drive");
		chk(hen | out, '0, "mid reset level");
		rpin = 1'h1;
		run(300, 1'h1);
		rst = 1'h1;
		tick();
		rst = 1'h0;
		chk(oe | hen | out, '0, "block reset buffers");
		chk(grole, '1, "block reset role");
		finish_test();
	end
endmodule
`default_nettype wire
